// ==== sfif_pkg.sv ====
// constants, opcode table and decode functions for the serial flash front end
// assumes a single-line serial bus, mode 0 or 3, host drives clock and select
`default_nettype none
package sfif_pkg;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RELEASE = 8'hab;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_RD_STAT1 = 8'h05;
    localparam logic [7:0] OP_RD_STAT2 = 8'h35;
    localparam logic [7:0] OP_RD_STAT3 = 8'h15;
    localparam logic [7:0] OP_WR_STAT1 = 8'h01;
    localparam logic [7:0] OP_WR_STAT2 = 8'h31;
    localparam logic [7:0] OP_WR_STAT3 = 8'h11;
    localparam logic [7:0] OP_RD_PARAM = 8'h5a;
    localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
    localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
    localparam logic [7:0] OP_RD_LOCK = 8'h3d;
    localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
    localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
    localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
    localparam logic [7:0] OP_RESET_EN = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_RD_UNIQUE = 8'h4b;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [2:0] DUMMY_ONE = 3'h1;
    localparam logic [2:0] DUMMY_RELEASE = 3'h3;
    localparam logic [2:0] DUMMY_UNIQUE = 3'h4;
    localparam logic [23:0] MASK_4K = 24'h00_0fff;
    localparam logic [23:0] MASK_32K = 24'h00_7fff;
    localparam logic [23:0] MASK_64K = 24'h00_ffff;
    localparam logic [23:0] ADDR_RESET = 24'h00_0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    // arbitrary value, not a real part code
    localparam logic [7:0] PART_CODE_DEFAULT = 8'h5a;
    localparam logic [3:0] DATA_CNT_MAX = 4'hf;
    // synchroniser reset, {aligned, toggle, select}
    localparam logic [2:0] SYNC_RESET = 3'h5;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_OPCODE = 3'b001,
        PH_ADDR = 3'b010,
        PH_DUMMY = 3'b011,
        PH_DATA = 3'b100
    } sfif_phase_type;

    typedef enum logic [3:0] {
        K_NOP = 4'b0000,
        K_WREN = 4'b0001,
        K_VWREN = 4'b0010,
        K_WRDI = 4'b0011,
        K_RELEASE = 4'b0100,
        K_SUSPEND = 4'b0101,
        K_RESUME = 4'b0110,
        K_ERASE = 4'b0111,
        K_PROG = 4'b1000,
        K_READ = 4'b1001,
        K_STATUS = 4'b1010,
        K_WSR = 4'b1011,
        K_LOCK = 4'b1100,
        K_PD = 4'b1101,
        K_RSTEN = 4'b1110,
        K_RST = 4'b1111
    } sfif_kind_type;

    function automatic sfif_kind_type sfif_kind(input logic [7:0] op);
        case (op)
            OP_WREN: sfif_kind = K_WREN;
            OP_VWREN: sfif_kind = K_VWREN;
            OP_WRDI: sfif_kind = K_WRDI;
            OP_RELEASE: sfif_kind = K_RELEASE;
            OP_SUSPEND: sfif_kind = K_SUSPEND;
            OP_RESUME: sfif_kind = K_RESUME;
            OP_SEC_ERASE, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: sfif_kind = K_ERASE;
            OP_SEC_PROG, OP_PAGE_PROG: sfif_kind = K_PROG;
            OP_SEC_READ, OP_READ, OP_FAST_READ, OP_RD_PARAM, OP_RD_LOCK,
            OP_RD_UNIQUE: sfif_kind = K_READ;
            OP_RD_STAT1, OP_RD_STAT2, OP_RD_STAT3: sfif_kind = K_STATUS;
            OP_WR_STAT1, OP_WR_STAT2, OP_WR_STAT3: sfif_kind = K_WSR;
            OP_GLOBAL_LOCK, OP_GLOBAL_UNLOCK, OP_BLOCK_LOCK,
            OP_BLOCK_UNLOCK: sfif_kind = K_LOCK;
            OP_POWER_DOWN: sfif_kind = K_PD;
            OP_RESET_EN: sfif_kind = K_RSTEN;
            OP_RESET: sfif_kind = K_RST;
            default: sfif_kind = K_NOP;
        endcase
    endfunction : sfif_kind

    function automatic logic [1:0] sfif_addr_bytes(input logic [7:0] op);
        case (op)
            OP_SEC_ERASE, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_SEC_PROG,
            OP_PAGE_PROG, OP_SEC_READ, OP_READ, OP_FAST_READ, OP_RD_PARAM,
            OP_RD_LOCK, OP_BLOCK_LOCK, OP_BLOCK_UNLOCK: sfif_addr_bytes = ADDR_BYTES;
            default: sfif_addr_bytes = 2'h0;
        endcase
    endfunction : sfif_addr_bytes

    function automatic logic [2:0] sfif_dummy_bytes(input logic [7:0] op);
        case (op)
            OP_FAST_READ, OP_SEC_READ, OP_RD_PARAM: sfif_dummy_bytes = DUMMY_ONE;
            OP_RELEASE: sfif_dummy_bytes = DUMMY_RELEASE;
            OP_RD_UNIQUE: sfif_dummy_bytes = DUMMY_UNIQUE;
            default: sfif_dummy_bytes = 3'h0;
        endcase
    endfunction : sfif_dummy_bytes
endpackage : sfif_pkg
`default_nettype wire

// ==== sfif_sync.sv ====
// two-flop level synchroniser, vector of independent bits
// assumes each bit is a slow level or a toggle from another domain
`default_nettype none
module sfif_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : sfif_sync
`default_nettype wire

// ==== sfif_link_shifter.sv ====
// link-clock side: bit capture, byte toggle, serial reply for status and part code
// assumes select high clears the frame; reply bytes are quasi-static while a frame runs
`default_nettype none
module sfif_link_shifter (
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_reset_n,
    input wire logic i_serial_in,
    input wire logic [7:0] i_stat1,
    input wire logic [7:0] i_stat2,
    input wire logic [7:0] i_stat3,
    input wire logic [7:0] i_part_code,
    output logic [7:0] o_byte,
    output logic o_byte_tgl,
    output logic o_aligned,
    output logic o_serial_out,
    output logic o_serial_out_en
);
    import sfif_pkg::*;

    logic [2:0] bit_q;
    logic [2:0] cnt_q;
    logic [6:0] shift_q;
    logic [7:0] op_q;
    logic [7:0] tx_q;
    logic [7:0] reply;
    logic reply_ok;
    logic [7:0] next_byte;

    assign next_byte = {shift_q, i_serial_in};

    // frame state, cleared whenever select is high
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_q <= 3'h0;
            cnt_q <= 3'h0;
            shift_q <= 7'h00;
            op_q <= BYTE_RESET;
        end else begin
            shift_q <= next_byte[6:0];
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
                if (cnt_q != 3'h7) begin
                    cnt_q <= cnt_q + 3'h1;
                end
                if (cnt_q == 3'h0) begin
                    op_q <= next_byte;
                end
            end
        end
    end

    // completed bytes, toggle and alignment survive the frame end
    always_ff @(posedge i_sclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_byte <= BYTE_RESET;
            o_byte_tgl <= 1'b0;
            o_aligned <= 1'b1;
        end else begin
            o_aligned <= (bit_q == 3'h7);
            if (bit_q == 3'h7) begin
                o_byte <= next_byte;
                o_byte_tgl <= ~o_byte_tgl;
            end
        end
    end

    always_comb begin
        reply = BYTE_RESET;
        reply_ok = 1'b0;
        case (sfif_kind(op_q))
            K_STATUS: begin
                reply_ok = 1'b1;
                if (op_q == OP_RD_STAT1) begin
                    reply = i_stat1;
                end else if (op_q == OP_RD_STAT2) begin
                    reply = i_stat2;
                end else begin
                    reply = i_stat3;
                end
            end
            K_RELEASE: begin
                reply_ok = (cnt_q > DUMMY_RELEASE);
                reply = i_part_code;
            end
            default: begin
                reply_ok = 1'b0;
            end
        endcase
    end

    // reply launched on the falling edge, repeats each byte until select rises
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_serial_out <= 1'b0;
            o_serial_out_en <= 1'b0;
            tx_q <= BYTE_RESET;
        end else if (bit_q == 3'h0 && cnt_q != 3'h0 && reply_ok) begin
            o_serial_out <= reply[7];
            tx_q <= {reply[6:0], 1'b0};
            o_serial_out_en <= 1'b1;
        end else if (o_serial_out_en) begin
            o_serial_out <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end
endmodule : sfif_link_shifter
`default_nettype wire

// ==== sfif_frontend.sv ====
// serial flash instruction front end: frames host commands, gates and issues array operations
// assumes an array engine on i_mclk that answers each started busy operation with i_op_done
`default_nettype none
module sfif_frontend #(
    parameter logic [7:0] PART_CODE = sfif_pkg::PART_CODE_DEFAULT
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_serial_in,
    input wire logic i_op_done,
    input wire logic [23:0] i_protect_limit,
    output logic o_serial_out,
    output logic o_serial_out_en,
    output logic o_op_start,
    output logic [7:0] o_op_code,
    output logic [23:0] o_op_addr,
    output logic o_prog_valid,
    output logic [7:0] o_prog_data,
    output logic [23:0] o_prog_addr,
    output logic o_rd_start,
    output logic o_rd_next,
    output logic [23:0] o_rd_addr,
    output logic o_write_latch,
    output logic o_busy,
    output logic o_power_down
);
    import sfif_pkg::*;

    logic [7:0] link_byte;
    logic link_tgl;
    logic link_aligned;
    logic [2:0] sync_out;
    logic cs_s;
    logic tgl_s;
    logic aligned_s;
    logic cs_d_q;
    logic tgl_d_q;
    logic end_d1_q;
    logic end_d2_q;
    logic frame_start;
    logic frame_end;
    logic byte_ev;
    sfif_phase_type ph_q;
    sfif_kind_type kind_q;
    logic [7:0] op_q;
    logic accept_q;
    logic [2:0] cnt_q;
    logic [23:0] addr_q;
    logic [7:0] col_q;
    logic [3:0] ndata_q;
    logic [7:0] wsr_data_q;
    logic [7:0] stat1_q;
    logic [7:0] stat2_q;
    logic [7:0] stat3_q;
    logic vsr_q;
    logic rsten_q;
    logic enter_data;
    logic done;
    logic exec_ok;
    logic start_op;
    logic soft_reset;
    sfif_kind_type new_kind;

    function automatic logic sfif_protected(input logic [7:0] op, input logic [23:0] addr,
                                            input logic [23:0] limit);
        case (op)
            OP_PAGE_PROG: sfif_protected = (addr < limit);
            OP_ERASE_4K: sfif_protected = ((addr & ~MASK_4K) < limit);
            OP_ERASE_32K: sfif_protected = ((addr & ~MASK_32K) < limit);
            OP_ERASE_64K: sfif_protected = ((addr & ~MASK_64K) < limit);
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: sfif_protected = (limit != ADDR_RESET);
            default: sfif_protected = 1'b0;
        endcase
    endfunction : sfif_protected

    sfif_link_shifter u_link (
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_reset_n(i_reset_n),
        .i_serial_in(i_serial_in),
        .i_stat1({stat1_q[7:2], o_write_latch, o_busy}),
        .i_stat2(stat2_q),
        .i_stat3(stat3_q),
        .i_part_code(PART_CODE),
        .o_byte(link_byte),
        .o_byte_tgl(link_tgl),
        .o_aligned(link_aligned),
        .o_serial_out(o_serial_out),
        .o_serial_out_en(o_serial_out_en)
    );

    sfif_sync #(
        .WIDTH(3),
        .RESET_VAL(SYNC_RESET)
    ) u_sync (
        .i_clk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_async({link_aligned, link_tgl, i_cs_n}),
        .o_sync(sync_out)
    );

    assign cs_s = sync_out[0];
    assign tgl_s = sync_out[1];
    assign aligned_s = sync_out[2];

    // edge detection on the synchronised levels
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cs_d_q <= 1'b1;
            tgl_d_q <= 1'b0;
            end_d1_q <= 1'b0;
            end_d2_q <= 1'b0;
        end else begin
            cs_d_q <= cs_s;
            tgl_d_q <= tgl_s;
            end_d1_q <= frame_end;
            end_d2_q <= end_d1_q;
        end
    end

    assign frame_start = cs_d_q & ~cs_s;
    assign frame_end = ~cs_d_q & cs_s;
    assign byte_ev = tgl_s ^ tgl_d_q;
    assign new_kind = sfif_kind(link_byte);
    assign enter_data = byte_ev && (ph_q == PH_OPCODE || ph_q == PH_ADDR || ph_q == PH_DUMMY) &&
        ((ph_q == PH_OPCODE && sfif_addr_bytes(link_byte) == 2'h0 && sfif_dummy_bytes(link_byte) == 3'h0) ||
         (ph_q == PH_ADDR && cnt_q[1:0] == sfif_addr_bytes(op_q) - 2'h1 && sfif_dummy_bytes(op_q) == 3'h0) ||
         (ph_q == PH_DUMMY && cnt_q == sfif_dummy_bytes(op_q) - 3'h1));

    // command phase sequencing
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ph_q <= PH_IDLE;
            kind_q <= K_NOP;
            op_q <= BYTE_RESET;
            accept_q <= 1'b0;
            cnt_q <= 3'h0;
            addr_q <= ADDR_RESET;
        end else if (frame_start) begin
            ph_q <= PH_OPCODE;
            cnt_q <= 3'h0;
        end else if (end_d2_q) begin
            ph_q <= PH_IDLE;
        end else if (byte_ev) begin
            case (ph_q)
                PH_OPCODE: begin
                    op_q <= link_byte;
                    kind_q <= new_kind;
                    accept_q <= (!o_busy || new_kind == K_STATUS) && (!o_power_down || new_kind == K_RELEASE);
                    addr_q <= ADDR_RESET;
                    cnt_q <= 3'h0;
                    if (sfif_addr_bytes(link_byte) != 2'h0) begin
                        ph_q <= PH_ADDR;
                    end else if (sfif_dummy_bytes(link_byte) != 3'h0) begin
                        ph_q <= PH_DUMMY;
                    end else begin
                        ph_q <= PH_DATA;
                    end
                end
                PH_ADDR: begin
                    addr_q <= {addr_q[15:0], link_byte};
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q[1:0] == sfif_addr_bytes(op_q) - 2'h1) begin
                        cnt_q <= 3'h0;
                        ph_q <= (sfif_dummy_bytes(op_q) != 3'h0) ? PH_DUMMY : PH_DATA;
                    end
                end
                PH_DUMMY: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == sfif_dummy_bytes(op_q) - 3'h1) begin
                        cnt_q <= 3'h0;
                        ph_q <= PH_DATA;
                    end
                end
                PH_DATA: begin
                    ph_q <= PH_DATA;
                end
                default: begin
                    ph_q <= PH_IDLE;
                end
            endcase
        end
    end

    // data bytes: program stream with page wrap, first status write byte
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ndata_q <= 4'h0;
            col_q <= BYTE_RESET;
            wsr_data_q <= BYTE_RESET;
            o_prog_valid <= 1'b0;
            o_prog_data <= BYTE_RESET;
            o_prog_addr <= ADDR_RESET;
        end else begin
            o_prog_valid <= 1'b0;
            if (frame_start) begin
                ndata_q <= 4'h0;
            end else if (byte_ev && ph_q == PH_DATA && accept_q) begin
                if (ndata_q != DATA_CNT_MAX) begin
                    ndata_q <= ndata_q + 4'h1;
                end
                if (ndata_q == 4'h0) begin
                    wsr_data_q <= link_byte;
                end
                if (kind_q == K_PROG) begin
                    o_prog_valid <= 1'b1;
                    o_prog_data <= link_byte;
                    o_prog_addr <= {addr_q[23:8], (ndata_q == 4'h0) ? addr_q[7:0] : col_q};
                    col_q <= ((ndata_q == 4'h0) ? addr_q[7:0] : col_q) + 8'h01;
                end
            end
        end
    end

    // read requests; release of reads needs no alignment
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_rd_start <= 1'b0;
            o_rd_next <= 1'b0;
            o_rd_addr <= ADDR_RESET;
        end else begin
            o_rd_start <= 1'b0;
            o_rd_next <= 1'b0;
            if (enter_data && kind_q == K_READ && accept_q && ph_q != PH_OPCODE) begin
                o_rd_start <= 1'b1;
                o_rd_addr <= (ph_q == PH_ADDR) ? {addr_q[15:0], link_byte} : addr_q;
            end else if (byte_ev && ph_q == PH_DATA && kind_q == K_READ && accept_q) begin
                o_rd_next <= 1'b1;
            end
        end
    end

    assign done = i_op_done && o_busy;
    // frame end checks: byte boundary, accepted, complete phases
    assign exec_ok = end_d2_q && accept_q && aligned_s && ph_q == PH_DATA;
    assign start_op = exec_ok && (
        ((kind_q == K_PROG) && ndata_q != 4'h0 && o_write_latch &&
         !sfif_protected(op_q, addr_q, i_protect_limit)) ||
        ((kind_q == K_ERASE) && o_write_latch && !sfif_protected(op_q, addr_q, i_protect_limit)) ||
        ((kind_q == K_WSR) && ndata_q != 4'h0 && (o_write_latch || vsr_q)) ||
        ((kind_q == K_LOCK) && o_write_latch) ||
        (kind_q == K_SUSPEND) || (kind_q == K_RESUME));
    assign soft_reset = exec_ok && kind_q == K_RST && rsten_q;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_op_start <= 1'b0;
            o_op_code <= BYTE_RESET;
            o_op_addr <= ADDR_RESET;
        end else begin
            o_op_start <= start_op;
            if (start_op) begin
                o_op_code <= op_q;
                o_op_addr <= addr_q;
            end
        end
    end

    // busy: set wins over a same-cycle completion
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
        end else if (start_op && (kind_q == K_PROG || kind_q == K_ERASE || kind_q == K_WSR)) begin
            o_busy <= 1'b1;
        end else if (done) begin
            o_busy <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_write_latch <= 1'b0;
        end else if (exec_ok && kind_q == K_WREN) begin
            o_write_latch <= 1'b1;
        end else if (done || soft_reset || (exec_ok && kind_q == K_WRDI)) begin
            o_write_latch <= 1'b0;
        end
    end

    // volatile status enable and reset enable last until the next accepted frame ends
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            vsr_q <= 1'b0;
            rsten_q <= 1'b0;
        end else if (end_d2_q && accept_q) begin
            vsr_q <= exec_ok && kind_q == K_VWREN;
            rsten_q <= exec_ok && kind_q == K_RSTEN;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_power_down <= 1'b0;
        end else if (end_d2_q && accept_q && kind_q == K_RELEASE) begin
            o_power_down <= 1'b0;
        end else if (exec_ok && kind_q == K_PD) begin
            o_power_down <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || soft_reset) begin
            stat1_q <= STAT_RESET;
            stat2_q <= STAT_RESET;
            stat3_q <= STAT_RESET;
        end else if (start_op && kind_q == K_WSR) begin
            case (op_q)
                OP_WR_STAT1: stat1_q <= wsr_data_q;
                OP_WR_STAT2: stat2_q <= wsr_data_q;
                default: stat3_q <= wsr_data_q;
            endcase
        end
    end
endmodule : sfif_frontend
`default_nettype wire

// ==== sfif_frontend_properties.sv ====
// port checks for the flash front end
// assumes it is bound onto sfif_frontend
`default_nettype none
module sfif_frontend_properties (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_cs_n,
    input wire logic i_op_done,
    input wire logic o_serial_out_en,
    input wire logic o_op_start,
    input wire logic o_prog_valid,
    input wire logic o_rd_start,
    input wire logic o_write_latch,
    input wire logic o_busy,
    input wire logic o_power_down
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    sequence done_s;
        o_busy && i_op_done && !o_op_start;
    endsequence
    busy_clear_a: assert property (done_s |=> !o_busy) else $error("busy kept");
    latch_clear_a: assert property (done_s |=> !o_write_latch) else $error("latch kept");
    start_pulse_a: assert property (o_op_start |=> !o_op_start) else $error("long start");
    prog_pulse_a: assert property (o_prog_valid |=> !o_prog_valid) else $error("long prog");
    idle_quiet_a: assert property (i_cs_n && $past(i_cs_n) |-> !o_serial_out_en) else $error("drive");
    busy_quiet_a: assert property (o_busy && $past(o_busy) |-> !(o_op_start || o_prog_valid || o_rd_start))
        else $error("busy op");
    pd_quiet_a: assert property (o_power_down && $past(o_power_down) |-> !(o_op_start || o_rd_start))
        else $error("asleep op");
    latch_rise_a: assert property ($rose(o_write_latch) |-> !o_busy) else $error("latch in busy");
endmodule : sfif_frontend_properties
bind sfif_frontend sfif_frontend_properties chk_u (.*);
`default_nettype wire

// ==== sfif_host_model.sv ====
// host controller model: clock, select and data
// assumes mode 0; clock runs only inside frames
`default_nettype none
module sfif_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_serial_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_sclk <= 1'b0;
        o_cs_n <= 1'b1;
        o_serial_in <= 1'b0;
    end
    task automatic frame(input logic [63:0] v, input int nb);
        o_cs_n = 1'b0;
        for (int k = 0; k < nb; k++) begin
            o_serial_in = v[63-k];
            #7.5 o_sclk = 1'b1;
            #7.5 o_sclk = 1'b0;
        end
        #7.5 o_cs_n = 1'b1;
        o_serial_in = ~o_serial_in;
        #100;
    endtask : frame
endmodule : sfif_host_model
`default_nettype wire

// ==== test_sfif_frontend.sv ====
// self-checking bench for the flash front end
// assumes host model on the link, bench as array engine
`default_nettype none
module test_sfif_frontend;
    timeunit 1ns;
    timeprecision 100ps;
    import sfif_pkg::*;
    logic i_mclk = 1'b0;
    logic i_reset_n;
    logic i_op_done = 1'b0;
    logic [23:0] i_protect_limit = 24'h00_0000;
    wire logic i_sclk, i_cs_n, i_serial_in;
    logic o_serial_out, o_serial_out_en, o_op_start, o_prog_valid, o_rd_start, o_rd_next;
    logic o_write_latch, o_busy, o_power_down;
    logic [7:0] o_op_code, o_prog_data;
    logic [23:0] o_op_addr, o_prog_addr, o_rd_addr;
    logic [31:0] cap = 32'h0000_0000;
    logic [7:0] rx = 8'h00;
    int n_mismatch = 0, samples_checked = 0, n_start = 0, n_rd = 0, n_nx = 0;
    always #5 i_mclk = ~i_mclk;
    sfif_host_model host_u (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_serial_in(i_serial_in));
    sfif_frontend dut_u (.*);
    always @(posedge i_mclk) begin
        n_start <= n_start + int'(o_op_start);
        n_rd <= n_rd + int'(o_rd_start);
        n_nx <= n_nx + int'(o_rd_next);
        if (o_prog_valid) cap <= {o_prog_addr, o_prog_data};
    end
    always @(posedge i_sclk) rx <= {rx[6:0], o_serial_out};
    task automatic chk(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic op_done();
        @(posedge i_mclk) i_op_done <= 1'b1;
        @(posedge i_mclk) i_op_done <= 1'b0;
        repeat (3) @(posedge i_mclk);
        chk("done", {o_busy, o_write_latch}, 0);
    endtask : op_done
    task automatic t_latch();
        host_u.frame({OP_WREN, 56'h0}, 11);
        chk("latch part", o_write_latch, 1'b0);
        host_u.frame({OP_WREN, 56'h0}, 8);
        chk("latch set", o_write_latch, 1'b1);
        host_u.frame({OP_WRDI, 56'h0}, 8);
        chk("latch clr", o_write_latch, 1'b0);
        $display("latch test done");
    endtask : t_latch
    task automatic t_prog();
        host_u.frame({OP_WREN, 56'h0}, 8);
        host_u.frame({OP_PAGE_PROG, 24'h00_12ff, 8'ha5, 8'h3c, 16'h0}, 48);
        chk("wrap", cap, 32'h0012_003c);
        chk("prog", {o_busy, o_op_code}, {1'b1, OP_PAGE_PROG});
        host_u.frame({OP_READ, 56'h0}, 32);
        chk("busy read", n_rd, 0);
        host_u.frame({OP_RD_STAT1, 56'h0}, 16);
        chk("busy status", rx, 8'h03);
        op_done();
        host_u.frame({OP_READ, 24'h00_0040, 32'h0}, 43);
        chk("read", {n_rd[7:0], o_rd_addr}, {8'h01, 24'h00_0040});
        chk("next", n_nx, 1);
        $display("program test done");
    endtask : t_prog
    task automatic t_protect();
        int s0;
        s0 = n_start;
        @(posedge i_mclk) i_protect_limit <= 24'h01_0000;
        host_u.frame({OP_WREN, 56'h0}, 8);
        host_u.frame({OP_ERASE_4K, 24'h00_f000, 32'h0}, 32);
        chk("protected", n_start, s0);
        host_u.frame({OP_ERASE_4K, 24'h01_0000, 32'h0}, 32);
        chk("erase", {n_start[7:0], o_op_addr}, {8'(s0 + 1), 24'h01_0000});
        op_done();
        $display("protect test done");
    endtask : t_protect
    task automatic t_power();
        host_u.frame({OP_POWER_DOWN, 56'h0}, 8);
        chk("asleep", o_power_down, 1'b1);
        host_u.frame({OP_WREN, 56'h0}, 8);
        chk("asleep wren", o_write_latch, 1'b0);
        host_u.frame({OP_RELEASE, 56'h0}, 40);
        chk("awake", o_power_down, 1'b0);
        chk("part code", rx, PART_CODE_DEFAULT);
        $display("power test done");
    endtask : t_power
    initial begin
        i_reset_n <= 1'b0;
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
        t_latch();
        t_prog();
        t_protect();
        t_power();
        stop_test();
    end
    initial begin
        #50000;
        n_mismatch++;
        stop_test();
    end
endmodule : test_sfif_frontend
`default_nettype wire
